// file: drosh_pkg.sv
// constants shared by the one-shot driver
// assumes a single 50 MHz clock domain
//
// Behaviour
// - reset low blocks pulses; hold during power-up
// - space trigger edges by forty percent period
// - rise mode: output fed back to fall pin
// - fall mode: output fed back to rise pin
// - unused inputs: rise low, fall/reset high
// - unused section: reset held low
package drosh_pkg;
    localparam int unsigned CLK_HZ       = 50_000_000;
    localparam int unsigned NUM_SECTIONS = 2;
    localparam int unsigned SPACING_PCT  = 40;
    localparam int unsigned PCT_FULL     = 100;
    localparam int unsigned CNT_W        = 24;
    localparam logic        RISE_IDLE    = 1'b0;
    localparam logic        FALL_IDLE    = 1'b1;

    typedef enum logic [1:0] {
        DROSH_OFF,
        DROSH_IDLE,
        DROSH_WAIT
    } drosh_state_e;

    typedef enum logic {
        DROSH_EDGE_RISE,
        DROSH_EDGE_FALL
    } drosh_edge_e;

    // least legal spacing between trigger edges in clocks, rounded up
    function automatic logic [CNT_W-1:0] min_spacing(input logic [CNT_W-1:0] period);
        logic [CNT_W+7:0] prod;
        prod = {8'h00, period} * SPACING_PCT[7:0];
        min_spacing = CNT_W'((prod + (CNT_W+8)'(PCT_FULL - 1)) / (CNT_W+8)'(PCT_FULL));
    endfunction : min_spacing
endpackage : drosh_pkg

// file: drosh_section.sv
// one host-side driver for one one-shot section
// assumes synchronous request inputs and released reset
`timescale 1ns/1ps
`default_nettype none
module drosh_section #(
    parameter int unsigned CNT_W = drosh_pkg::CNT_W
) (
    input  wire logic             clk,
    input  wire logic             rst_n,
    input  wire logic             enable,
    input  wire logic             fire,
    input  wire logic             stop,
    input  wire logic             edge_sel,
    input  wire logic             retrig,
    input  wire logic [CNT_W-1:0] period,
    input  wire logic             pulse_q,
    input  wire logic             pulse_qn,
    output logic                  rise_trigger_in,
    output logic                  fall_trigger_in,
    output logic                  section_reset_n,
    output logic                  ready,
    output logic                  busy
);
    drosh_pkg::drosh_state_e state;
    logic [CNT_W-1:0]        gap;
    logic                    nonretrig;
    logic                    edge_is_fall;

    assign nonretrig    = !retrig;
    assign edge_is_fall = (edge_sel == drosh_pkg::DROSH_EDGE_FALL);
    assign busy         = pulse_q;
    // handshake: edge accepted only when spacing met and stop low; enable acts one cycle late via state
    assign ready        = (state == drosh_pkg::DROSH_IDLE) && !stop;

    ////////////////////////////////////////////////////////////////
    // state and spacing counter
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            state <= drosh_pkg::DROSH_OFF;
            gap   <= '0;
        end else begin
            unique case (state)
                drosh_pkg::DROSH_OFF: begin
                    if (enable && !stop) begin
                        state <= drosh_pkg::DROSH_IDLE;
                    end
                end
                drosh_pkg::DROSH_IDLE: begin
                    if (!enable) begin
                        state <= drosh_pkg::DROSH_OFF;
                    end else if (fire && !stop) begin
                        gap   <= drosh_pkg::min_spacing(period);
                        state <= drosh_pkg::DROSH_WAIT;
                    end
                end
                drosh_pkg::DROSH_WAIT: begin
                    if (!enable || stop) begin
                        state <= drosh_pkg::DROSH_OFF;
                    end else if (gap <= CNT_W'(1)) begin
                        state <= drosh_pkg::DROSH_IDLE;
                    end else begin
                        gap <= gap - CNT_W'(1);
                    end
                end
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////
    // reset pin: low when disabled or stopping
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            section_reset_n <= 1'b0;
        end else begin
            section_reset_n <= enable && !stop;
        end
    end

    ////////////////////////////////////////////////////////////////
    // trigger pins: one edge per accepted fire, feedback when non-retrig
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rise_trigger_in <= drosh_pkg::RISE_IDLE;
            fall_trigger_in <= drosh_pkg::FALL_IDLE;
        end else begin
            // feedback pin leaves its enabling level on the same edge the trigger pin returns to idle,
            // so its own transition is never taken as a second trigger
            if (edge_is_fall) begin
                fall_trigger_in <= !(ready && fire);
                rise_trigger_in <= nonretrig ? (pulse_q || !fall_trigger_in) : drosh_pkg::RISE_IDLE;
            end else begin
                rise_trigger_in <= ready && fire;
                fall_trigger_in <= nonretrig ? (pulse_qn && !rise_trigger_in) : drosh_pkg::FALL_IDLE;
            end
        end
    end
endmodule : drosh_section
`default_nettype wire

// file: drosh_host.sv
// host driver for a dual one-shot part
// assumes pulse outputs of the part are synchronous to clk
`timescale 1ns/1ps
`default_nettype none
module drosh_host #(
    parameter int unsigned CNT_W = drosh_pkg::CNT_W
) (
    input  wire logic                                  clk,
    input  wire logic                                  resetn,
    input  wire logic [drosh_pkg::NUM_SECTIONS-1:0]    enable,
    input  wire logic [drosh_pkg::NUM_SECTIONS-1:0]    fire,
    input  wire logic [drosh_pkg::NUM_SECTIONS-1:0]    stop,
    input  wire logic [drosh_pkg::NUM_SECTIONS-1:0]    edge_sel,
    input  wire logic [drosh_pkg::NUM_SECTIONS-1:0]    retrig,
    input  wire logic [drosh_pkg::NUM_SECTIONS*CNT_W-1:0] period,
    input  wire logic [drosh_pkg::NUM_SECTIONS-1:0]    pulse_q,
    input  wire logic [drosh_pkg::NUM_SECTIONS-1:0]    pulse_qn,
    output logic [drosh_pkg::NUM_SECTIONS-1:0]         rise_trigger_in,
    output logic [drosh_pkg::NUM_SECTIONS-1:0]         fall_trigger_in,
    output logic [drosh_pkg::NUM_SECTIONS-1:0]         section_reset_n,
    output logic [drosh_pkg::NUM_SECTIONS-1:0]         ready,
    output logic [drosh_pkg::NUM_SECTIONS-1:0]         busy
);
    logic rst_meta_n;
    logic rst_n;

    ////////////////////////////////////////////////////////////////
    // reset release
    always_ff @(posedge clk or negedge resetn) begin
        if (!resetn) begin
            rst_meta_n <= 1'b0;
            rst_n      <= 1'b0;
        end else begin
            rst_meta_n <= 1'b1;
            rst_n      <= rst_meta_n;
        end
    end

    ////////////////////////////////////////////////////////////////
    // independent sections
    for (genvar s = 0; s < drosh_pkg::NUM_SECTIONS; s++) begin : g_sec
        drosh_section #(.CNT_W(CNT_W)) u_sec (
            .clk             (clk),
            .rst_n           (rst_n),
            .enable          (enable[s]),
            .fire            (fire[s]),
            .stop            (stop[s]),
            .edge_sel        (edge_sel[s]),
            .retrig          (retrig[s]),
            .period          (period[s*CNT_W +: CNT_W]),
            .pulse_q         (pulse_q[s]),
            .pulse_qn        (pulse_qn[s]),
            .rise_trigger_in (rise_trigger_in[s]),
            .fall_trigger_in (fall_trigger_in[s]),
            .section_reset_n (section_reset_n[s]),
            .ready           (ready[s]),
            .busy            (busy[s])
        );
    end
endmodule : drosh_host
`default_nettype wire

// file: drosh_host_properties.sv
// checker on the ports of the one-shot host driver
// assumes it is bound onto drosh_host
`timescale 1ns/1ps
`default_nettype none
module drosh_host_props (
    input wire logic       clk,
    input wire logic       resetn,
    input wire logic [1:0] enable,
    input wire logic [1:0] fire,
    input wire logic [1:0] stop,
    input wire logic [1:0] edge_sel,
    input wire logic [1:0] retrig,
    input wire logic [1:0] ready,
    input wire logic [1:0] rise_trigger_in,
    input wire logic [1:0] fall_trigger_in,
    input wire logic [1:0] section_reset_n
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!resetn);
    sequence s_take;
        fire[0] && ready[0];
    endsequence
    AST_OFF_HOLD: assert property (!enable[1] |=> !section_reset_n[1])
        else $error("idle section not held");
    AST_STOP_RESET: assert property (stop[1] |=> !section_reset_n[1])
        else $error("stop ignored");
    AST_STOP_READY: assert property (stop[1] |-> !ready[1])
        else $error("ready during stop");
    AST_FEED_FALL: assert property (!retrig[0] && !edge_sel[0] && rise_trigger_in[0] |=> !fall_trigger_in[0])
        else $error("fall feedback pin not low after trigger");
    AST_FEED_RISE: assert property (!retrig[0] && edge_sel[0] && !fall_trigger_in[0] |=> rise_trigger_in[0])
        else $error("rise feedback pin not high after trigger");
    AST_SPACING: assert property (s_take |=> !ready[0])
        else $error("fire taken back to back");
    AST_RISE_EDGE: assert property (s_take ##0 !edge_sel[0] |=> rise_trigger_in[0] ##1 !rise_trigger_in[0])
        else $error("rise trigger pulse wrong");
    AST_FALL_EDGE: assert property (s_take ##0 edge_sel[0] |=> !fall_trigger_in[0] ##1 fall_trigger_in[0])
        else $error("fall trigger pulse wrong");
    AST_IDLE_FALL: assert property (retrig[0] && !edge_sel[0] |=> fall_trigger_in[0])
        else $error("unused fall pin not high");
    AST_IDLE_RISE: assert property (retrig[0] && edge_sel[0] |=> !rise_trigger_in[0])
        else $error("unused rise pin not low");
endmodule : drosh_host_props
bind drosh_host drosh_host_props props_u (.clk, .resetn, .enable, .fire, .stop, .edge_sel, .retrig, .ready,
    .rise_trigger_in, .fall_trigger_in, .section_reset_n);
`default_nettype wire

// file: drosh_part.sv
// behavioural model of the dual one-shot part
// assumes its pins come from drosh_host on the same clock
`timescale 1ns/1ps
`default_nettype none
module drosh_part #(
    parameter int unsigned CNT_W = 24
) (
    input  wire logic               clk,
    input  wire logic [1:0]         rise_trigger_in,
    input  wire logic [1:0]         fall_trigger_in,
    input  wire logic [1:0]         section_reset_n,
    input  wire logic [2*CNT_W-1:0] period,
    output logic      [1:0]         pulse_q,
    output logic      [1:0]         pulse_qn
);
    logic [CNT_W-1:0] cnt [2] = '{'0, '0};
    logic [1:0]       prev_rise = 2'b00;
    logic [1:0]       prev_fall = 2'b11;
    always @(posedge clk) begin
        for (int s = 0; s < 2; s++) begin
            prev_rise[s] <= rise_trigger_in[s];
            prev_fall[s] <= fall_trigger_in[s];
            if (!section_reset_n[s]) cnt[s] <= '0;
            // an edge counts only while the other pin held its enabling level on both samples
            else if ((rise_trigger_in[s] && !prev_rise[s] && fall_trigger_in[s] && prev_fall[s]) ||
                     (!fall_trigger_in[s] && prev_fall[s] && !rise_trigger_in[s] && !prev_rise[s]))
                cnt[s] <= period[s*CNT_W +: CNT_W];
            else if (cnt[s] != '0) cnt[s] <= cnt[s] - 1'b1;
        end
    end
    always_comb begin
        for (int s = 0; s < 2; s++) pulse_q[s] = section_reset_n[s] && cnt[s] != '0;
        pulse_qn = ~pulse_q;
    end
endmodule : drosh_part
`default_nettype wire

// file: drosh_host_tb_top.sv
// self-checking bench for the one-shot host driver
// assumes drosh_part stands in for the one-shot part
`timescale 1ns/1ps
`default_nettype none
module drosh_host_tb_top;
    logic        clk = 1'b0;
    logic        resetn = 1'b0;
    logic [1:0]  enable = 2'b01, fire = 2'b00, stop = 2'b00, edge_sel = 2'b00, retrig = 2'b11;
    logic [47:0] period = '0;
    logic [1:0]  pulse_q, pulse_qn, rise_trigger_in, fall_trigger_in, section_reset_n, ready, busy;
    int          error_cnt = 0, tests_run = 0, a, b, p, e;
    int          hi [2] = '{0, 0};
    always #10 clk = ~clk;
    drosh_host dut_u (.clk, .resetn, .enable, .fire, .stop, .edge_sel, .retrig, .period, .pulse_q, .pulse_qn,
        .rise_trigger_in, .fall_trigger_in, .section_reset_n, .ready, .busy);
    drosh_part part_u (.clk, .rise_trigger_in, .fall_trigger_in, .section_reset_n, .period,
        .pulse_q, .pulse_qn);
    always @(posedge clk)
        for (int s = 0; s < 2; s++) hi[s] += int'(pulse_q[s]);
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask : chk
    task automatic conclude();
        if (error_cnt == 0 && tests_run > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : conclude
    task automatic shoot(input int s, output int at);
        int n;
        n = 0;
        @(posedge clk);
        fire[s] <= 1'b1;
        do begin
            @(posedge clk);
            n++;
        end while (ready[s] !== 1'b1 && n < 200);
        fire[s] <= 1'b0;
        at = int'($time / 20);
        #1 chk(n < 200, 1'b1);
        chk(edge_sel[s] ? fall_trigger_in[s] : rise_trigger_in[s], !edge_sel[s]);
        if (retrig[s]) chk(edge_sel[s] ? rise_trigger_in[s] : fall_trigger_in[s], !edge_sel[s]);
        chk(ready[s], 1'b0);
    endtask : shoot
    initial begin
        p = $urandom(32'h31EA);
        repeat (5) @(posedge clk);
        chk({section_reset_n, rise_trigger_in, fall_trigger_in}, 6'b000011);
        resetn <= 1'b1;
        repeat (6) @(posedge clk);
        chk(section_reset_n[1], 1'b0);
        for (int k = 0; k < 4; k++) begin
            @(posedge clk);
            p = 6 + $urandom % 20;
            period[23:0] <= 24'(p);
            edge_sel[0] <= k[0];
            retrig[0] <= !k[1];
            repeat (3) @(posedge clk);
            #1 hi[0] = 0;
            shoot(0, a);
            shoot(0, b);
            if (k < 2) e = (b - a <= p) ? b - a + p : 2 * p;
            else e = (b - a < p) ? p : 2 * p;
            repeat (2 * p + 6) @(posedge clk);
            #1 chk(hi[0], e);
        end
        @(posedge clk);
        enable[1] <= 1'b1;
        edge_sel[1] <= 1'b1;
        period[47:24] <= 24'h00001E;
        repeat (4) @(posedge clk);
        #1 hi[1] = 0;
        shoot(1, a);
        repeat (5) @(posedge clk);
        stop[1] <= 1'b1;
        b = int'($time / 20);
        chk(busy, 2'b10);
        @(posedge clk);
        stop[1] <= 1'b0;
        #1 chk({section_reset_n[1], pulse_q[1]}, 2'b00);
        repeat (40) @(posedge clk);
        #1 chk(hi[1], b - a);
        chk(busy, pulse_q);
        conclude();
    end
    initial begin
        #100us;
        error_cnt++;
        conclude();
    end
endmodule : drosh_host_tb_top
`default_nettype wire
